// File: pack_prot_defs.vh
`ifndef PACK_PROT_DEFS_VH
`define PACK_PROT_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_STATUS 4'h0
`define ADDR_OUT_CTL 4'h1
`define ADDR_STATE_CTL 4'h2
`define ADDR_FUNC_CTL 4'h3
`define ADDR_CELL_SEL 4'h4
`define ADDR_OLV 4'h5
`define ADDR_OLT 4'h6
`define ADDR_SCC 4'h7
`define ADDR_SCD 4'h8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ST_SC_DSG 0
`define ST_SC_CHG 1
`define ST_OL 2
`define ST_WDF 3
`define ST_SLEEP 4
`define OC_FAULT_LATCH_CLEAR 0
`define OC_DSG 1
`define OC_CHG 2
`define OC_ZV 3
`define OC_OD 4
`define FC_AMP_EN 0
`define FC_THERMISTOR_BIAS_OUT 5
`define CS_ELEM_LO 0
`define CS_ELEM_HI 1
`define CS_CAL_LO 2
`define CS_CAL_HI 3
`define CS_BAL_LSB 4
`define DLY_LSB 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_REG8 8'h00

// ----------------------------------------
// Monitor path codes
// ----------------------------------------
`define MON_OFF 3'h0
`define MON_REF_DIRECT 3'h1
`define MON_REF_SCALED 3'h2
`define MON_CELL_A 3'h3
`define MON_CELL_B 3'h4
`define MON_CELL_C 3'h5

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 40
`define WD_START_MS 700
`define WD_STOP_NS 100000
// Sized to the parameters they seed: 700 ms and 100 us of 40 ns clocks
`define WD_START_CYCLES 25'h10B0760
`define WD_STOP_CYCLES 12'h9C4
// Ticks of a 320 ns host tick: 1 ms and one 61 us short step
`define TICKS_PER_MS 12'hC35
`define TICKS_PER_SC_STEP 12'hBE

`endif

// File: fault_blank_timer.v
`timescale 1ns/1ps

// Counts host tick edges while a fault condition is held
module fault_blank_timer #(
  parameter W = 20
) (
  input wire clk_i,
  input wire nrst_i,
  input wire ce_i,
  input wire tick_i,
  input wire cond_i,
  input wire [W-1:0] limit_i,
  output wire fire_o
);

  reg [W-1:0] cnt_reg;
  reg fire_reg;
  wire sat;

  assign sat = &cnt_reg;
  assign fire_o = fire_reg;

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_reg <= {W{1'b0}};
      fire_reg <= 1'b0;
    end else if (ce_i) begin
      // Condition dropping restarts the blanking window
      if (!cond_i) begin
        cnt_reg <= {W{1'b0}};
      end else if (tick_i && !sat) begin
        cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
      end
      fire_reg <= cond_i && (cnt_reg >= limit_i);
    end
  end

endmodule // fault_blank_timer

// File: pack_protection_fault_control.v
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "pack_prot_defs.vh"

module pack_protection_fault_control #(
  parameter [24:0] WD_START_CYCLES = `WD_START_CYCLES,
  parameter [11:0] TICKS_PER_MS = `TICKS_PER_MS,
  parameter [11:0] TICKS_PER_SC_STEP = `TICKS_PER_SC_STEP
) (
  input wire clk_i,
  input wire nrst_i,
  input wire ce_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output wire [7:0] rdata_o,
  input wire host_tick_in_i,
  input wire overload_det_i,
  input wire short_dsg_det_i,
  input wire short_chg_det_i,
  input wire sleep_pin_i,
  input wire precharge_select_in_i,
  output wire discharge_fet_drive_o,
  output wire charge_fet_drive_o,
  output wire zero_cell_charge_fet_drive_o,
  output wire alert_out_n_o,
  output wire thermistor_bias_out_o,
  output wire open_drain_out_o,
  output wire [3:0] balance_en_o,
  output wire [2:0] monitor_src_o
);

  localparam [11:0] WD_STOP = `WD_STOP_CYCLES;

  // ----------------------------------------
  // Monitor routing decode
  // ----------------------------------------
  function [2:0] mon_route;
    input [7:0] sel;
    input amp_en;
    reg [1:0] cal;
    reg [1:0] elem;
    begin
      cal = {sel[`CS_CAL_HI], sel[`CS_CAL_LO]};
      elem = {sel[`CS_ELEM_HI], sel[`CS_ELEM_LO]};
      mon_route = `MON_OFF;
      if (amp_en) begin
        case (cal)
          2'b11: if (elem == 2'b00) mon_route = `MON_REF_DIRECT;
          2'b10: if (elem == 2'b00) mon_route = `MON_REF_SCALED;
          2'b00: begin
            case (elem)
              2'b01: mon_route = `MON_CELL_A;
              2'b10: mon_route = `MON_CELL_B;
              2'b11: mon_route = `MON_CELL_C;
              default: mon_route = `MON_OFF;
            endcase
          end
          default: mon_route = `MON_OFF;
        endcase
      end
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Order: tick, overload, short dsg, short chg, sleep, precharge
  reg [5:0] meta_reg;
  reg [5:0] sync_reg;
  reg tick_prev_reg;
  reg sleep_prev_reg;
  wire tick_s;
  wire ol_s;
  wire scd_s;
  wire scc_s;
  wire sleep_s;
  wire pms_s;
  wire tick_edge;

  assign tick_s = sync_reg[0];
  assign ol_s = sync_reg[1];
  assign scd_s = sync_reg[2];
  assign scc_s = sync_reg[3];
  assign sleep_s = sync_reg[4];
  assign pms_s = sync_reg[5];
  assign tick_edge = tick_s && !tick_prev_reg;

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      meta_reg <= 6'h00;
      sync_reg <= 6'h00;
      tick_prev_reg <= 1'b0;
      sleep_prev_reg <= 1'b0;
    end else if (ce_i) begin
      meta_reg <= {precharge_select_in_i, sleep_pin_i, short_chg_det_i,
                   short_dsg_det_i, overload_det_i, host_tick_in_i};
      sync_reg <= meta_reg;
      tick_prev_reg <= tick_s;
      sleep_prev_reg <= sleep_s;
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  reg [7:0] out_ctl_reg;
  reg [7:0] state_ctl_reg;
  reg [7:0] func_ctl_reg;
  reg [7:0] cell_sel_reg;
  reg [7:0] olv_reg;
  reg [7:0] olt_reg;
  reg [7:0] scc_reg;
  reg [7:0] scd_reg;
  reg [7:0] rdata_reg;
  reg init_reg;
  wire wr_oc;
  wire rd_status;

  assign wr_oc = wr_i && (addr_i == `ADDR_OUT_CTL);
  assign rd_status = rd_i && (addr_i == `ADDR_STATUS);
  assign rdata_o = rdata_reg;

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      out_ctl_reg <= `RST_REG8;
      state_ctl_reg <= `RST_REG8;
      func_ctl_reg <= `RST_REG8;
      cell_sel_reg <= `RST_REG8;
      olv_reg <= `RST_REG8;
      olt_reg <= `RST_REG8;
      scc_reg <= `RST_REG8;
      scd_reg <= `RST_REG8;
      init_reg <= 1'b1;
    end else if (ce_i && wr_i) begin
      case (addr_i)
        `ADDR_OUT_CTL: begin
          out_ctl_reg <= wdata_i;
          init_reg <= 1'b0;
        end
        `ADDR_STATE_CTL: state_ctl_reg <= wdata_i;
        `ADDR_FUNC_CTL: func_ctl_reg <= wdata_i;
        `ADDR_CELL_SEL: cell_sel_reg <= wdata_i;
        `ADDR_OLV: olv_reg <= wdata_i;
        `ADDR_OLT: olt_reg <= wdata_i;
        `ADDR_SCC: scc_reg <= wdata_i;
        `ADDR_SCD: scd_reg <= wdata_i;
        default: init_reg <= init_reg;
      endcase
    end
  end

  // ----------------------------------------
  // Latch clear toggle
  // ----------------------------------------
  reg clr_armed_reg;
  wire fault_latch_clear_rise;
  wire fault_latch_clear_clear;

  // Separate writes: 0 to 1 arms, 1 to 0 fires
  assign fault_latch_clear_rise = wr_oc && wdata_i[`OC_FAULT_LATCH_CLEAR] && !out_ctl_reg[`OC_FAULT_LATCH_CLEAR];
  assign fault_latch_clear_clear = wr_oc && !wdata_i[`OC_FAULT_LATCH_CLEAR] && out_ctl_reg[`OC_FAULT_LATCH_CLEAR]
                       && clr_armed_reg;

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      clr_armed_reg <= 1'b0;
    end else if (ce_i) begin
      if (fault_latch_clear_clear) begin
        clr_armed_reg <= 1'b0;
      end else if (fault_latch_clear_rise) begin
        clr_armed_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Blanking delay timers
  // ----------------------------------------
  wire [19:0] ol_lim;
  wire [19:0] scd_lim;
  wire [19:0] scc_lim;
  wire ol_fire;
  wire scd_fire;
  wire scc_fire;

  // Overload delay in odd milliseconds, short delay in whole steps
  assign ol_lim = {15'd0, olt_reg[3:0], 1'b1} * {8'd0, TICKS_PER_MS};
  assign scd_lim = {16'd0, scd_reg[7:`DLY_LSB]} * {8'd0, TICKS_PER_SC_STEP};
  assign scc_lim = {16'd0, scc_reg[7:`DLY_LSB]} * {8'd0, TICKS_PER_SC_STEP};

  fault_blank_timer #(.W(20)) u_ol_timer (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .tick_i(tick_edge),
    .cond_i(ol_s),
    .limit_i(ol_lim),
    .fire_o(ol_fire)
  );

  fault_blank_timer #(.W(20)) u_scd_timer (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .tick_i(tick_edge),
    .cond_i(scd_s),
    .limit_i(scd_lim),
    .fire_o(scd_fire)
  );

  fault_blank_timer #(.W(20)) u_scc_timer (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .tick_i(tick_edge),
    .cond_i(scc_s),
    .limit_i(scc_lim),
    .fire_o(scc_fire)
  );

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  reg wd_started_reg;
  reg wd_active_reg;
  reg [24:0] wd_cnt_reg;
  wire wd_trip;

  assign wd_trip = wd_started_reg ? (wd_cnt_reg >= {13'd0, WD_STOP} - 25'd1)
                                  : (wd_cnt_reg >= WD_START_CYCLES - 25'd1);

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      wd_started_reg <= 1'b0;
      wd_active_reg <= 1'b0;
      wd_cnt_reg <= 25'd0;
    end else if (ce_i) begin
      if (tick_edge) begin
        wd_started_reg <= 1'b1;
        wd_active_reg <= 1'b0;
        wd_cnt_reg <= 25'd0;
      end else if (wd_trip) begin
        wd_active_reg <= 1'b1;
      end else begin
        wd_cnt_reg <= wd_cnt_reg + 25'd1;
      end
    end
  end

  // ----------------------------------------
  // Fault latches and status
  // ----------------------------------------
  reg scd_flag_reg;
  reg scc_flag_reg;
  reg ol_flag_reg;
  reg wdf_flag_reg;
  reg wd_prev_reg;
  wire new_fault;
  wire [7:0] status;

  assign new_fault = (scd_fire && !scd_flag_reg) || (scc_fire && !scc_flag_reg)
                     || (ol_fire && !ol_flag_reg);
  assign status = {3'b000, sleep_s, wdf_flag_reg, ol_flag_reg,
                   scc_flag_reg, scd_flag_reg};

  // Set wins over a clear in the same cycle
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      scd_flag_reg <= 1'b0;
      scc_flag_reg <= 1'b0;
      ol_flag_reg <= 1'b0;
      wdf_flag_reg <= 1'b0;
      wd_prev_reg <= 1'b0;
    end else if (ce_i) begin
      scd_flag_reg <= scd_fire || (scd_flag_reg && !fault_latch_clear_clear);
      scc_flag_reg <= scc_fire || (scc_flag_reg && !fault_latch_clear_clear);
      ol_flag_reg <= ol_fire || (ol_flag_reg && !fault_latch_clear_clear);
      wdf_flag_reg <= wd_active_reg || (wdf_flag_reg && !fault_latch_clear_clear);
      wd_prev_reg <= wd_active_reg;
    end
  end

  // ----------------------------------------
  // Alert
  // ----------------------------------------
  reg alert_n_reg;
  reg alert_ok_reg;
  wire alert_evt;
  wire alert_rel;

  assign alert_evt = new_fault || (sleep_s != sleep_prev_reg)
                     || (wd_active_reg && !wd_prev_reg);
  assign alert_rel = rd_status && alert_ok_reg;
  assign alert_out_n_o = alert_n_reg;

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      alert_n_reg <= 1'b1;
      alert_ok_reg <= 1'b0;
    end else if (ce_i) begin
      if (alert_evt) begin
        alert_n_reg <= 1'b0;
        alert_ok_reg <= 1'b0;
      end else begin
        if (alert_rel) begin
          alert_n_reg <= 1'b1;
          alert_ok_reg <= 1'b0;
        end else if (fault_latch_clear_clear) begin
          alert_ok_reg <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_reg <= 8'h00;
    end else if (ce_i) begin
      if (rd_i) begin
        case (addr_i)
          `ADDR_STATUS: rdata_reg <= status;
          `ADDR_OUT_CTL: rdata_reg <= out_ctl_reg;
          `ADDR_STATE_CTL: rdata_reg <= state_ctl_reg;
          `ADDR_FUNC_CTL: rdata_reg <= func_ctl_reg;
          `ADDR_CELL_SEL: rdata_reg <= cell_sel_reg;
          `ADDR_OLV: rdata_reg <= olv_reg;
          `ADDR_OLT: rdata_reg <= olt_reg;
          `ADDR_SCC: rdata_reg <= scc_reg;
          `ADDR_SCD: rdata_reg <= scd_reg;
          default: rdata_reg <= 8'h00;
        endcase
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Output drives
  // ----------------------------------------
  reg dsg_reg;
  reg chg_reg;
  reg zv_reg;
  reg thermistor_bias_out_reg;
  reg od_reg;
  reg [3:0] bal_reg;
  reg [2:0] mon_reg;
  wire prot_off;

  // Fresh fires counted so the drive drops without waiting a cycle
  assign prot_off = scd_flag_reg || scc_flag_reg || ol_flag_reg
                    || scd_fire || scc_fire || ol_fire || wd_active_reg;

  assign discharge_fet_drive_o = dsg_reg;
  assign charge_fet_drive_o = chg_reg;
  assign zero_cell_charge_fet_drive_o = zv_reg;
  assign thermistor_bias_out_o = thermistor_bias_out_reg;
  assign open_drain_out_o = od_reg;
  assign balance_en_o = bal_reg;
  assign monitor_src_o = mon_reg;

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      dsg_reg <= 1'b0;
      chg_reg <= 1'b0;
      zv_reg <= 1'b0;
      thermistor_bias_out_reg <= 1'b0;
      od_reg <= 1'b0;
      bal_reg <= 4'h0;
      mon_reg <= `MON_OFF;
    end else if (ce_i) begin
      if (prot_off) begin
        dsg_reg <= 1'b0;
        chg_reg <= 1'b0;
        zv_reg <= 1'b0;
      end else if (init_reg) begin
        dsg_reg <= 1'b0;
        chg_reg <= pms_s;
        zv_reg <= 1'b0;
      end else begin
        dsg_reg <= out_ctl_reg[`OC_DSG];
        chg_reg <= out_ctl_reg[`OC_CHG];
        zv_reg <= out_ctl_reg[`OC_ZV];
      end
      thermistor_bias_out_reg <= func_ctl_reg[`FC_THERMISTOR_BIAS_OUT];
      od_reg <= out_ctl_reg[`OC_OD];
      bal_reg <= cell_sel_reg[7:`CS_BAL_LSB];
      mon_reg <= mon_route(cell_sel_reg, func_ctl_reg[`FC_AMP_EN]);
    end
  end

endmodule // pack_protection_fault_control

// File: pack_protection_fault_control_sva.sv
`timescale 1ns/1ps
`include "pack_prot_defs.vh"
module pack_protection_fault_control_sva #(
  parameter [24:0] WD_START_CYCLES = 25'd2000
) (
  input wire clk_i,
  input wire nrst_i,
  input wire ce_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire host_tick_in_i,
  input wire short_dsg_det_i,
  input wire short_chg_det_i,
  input wire precharge_select_in_i,
  input wire discharge_fet_drive_o,
  input wire charge_fet_drive_o,
  input wire zero_cell_charge_fet_drive_o,
  input wire alert_out_n_o,
  input wire thermistor_bias_out_o,
  input wire open_drain_out_o,
  input wire [3:0] balance_en_o
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  // Margin covers the pin synchroniser lag
  wire [25:0] wd_lim = (WD_START_CYCLES > 25'd2500 ? {1'b0, WD_START_CYCLES} : 26'd2500) + 26'd16;
  wire fets_off = !discharge_fet_drive_o && !charge_fet_drive_o && !zero_cell_charge_fet_drive_o;
  reg tick_q;
  reg [25:0] idle_cnt;
  reg oc_written;
  always @(posedge clk_i) begin
    tick_q <= host_tick_in_i;
    if (!nrst_i || (host_tick_in_i && !tick_q)) idle_cnt <= 26'h0000000;
    else if (idle_cnt != 26'h3FFFFFF) idle_cnt <= idle_cnt + 26'h0000001;
    if (!nrst_i) oc_written <= 1'b0;
    else if (ce_i && wr_i && addr_i == `ADDR_OUT_CTL) oc_written <= 1'b1;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_od_follow;
    logic v;
    (ce_i && wr_i && addr_i == `ADDR_OUT_CTL, v = wdata_i[4]) |-> ##2 open_drain_out_o == v;
  endproperty
  a_od_follow: assert property (p_od_follow) else $error("open drain mismatch");
  property p_thermistor_bias_out_follow;
    logic v;
    (ce_i && wr_i && addr_i == `ADDR_FUNC_CTL, v = wdata_i[5]) |-> ##2 thermistor_bias_out_o == v;
  endproperty
  a_thermistor_bias_out_follow: assert property (p_thermistor_bias_out_follow) else $error("thermistor mismatch");
  property p_bal_follow;
    logic [3:0] v;
    (ce_i && wr_i && addr_i == `ADDR_CELL_SEL, v = wdata_i[7:4]) |-> ##2 balance_en_o == v;
  endproperty
  a_bal_follow: assert property (p_bal_follow) else $error("balance mismatch");
  property p_init_off;
    !oc_written |-> !discharge_fet_drive_o && !zero_cell_charge_fet_drive_o;
  endproperty
  a_init_off: assert property (p_init_off) else $error("fet on in init state");
  property p_strap;
    $rose(nrst_i) |-> ##[2:4] charge_fet_drive_o == precharge_select_in_i;
  endproperty
  a_strap: assert property (p_strap) else $error("charge drive ignores strap");
  property p_alert_release;
    $rose(alert_out_n_o) |-> $past(rd_i) && $past(addr_i) == `ADDR_STATUS;
  endproperty
  a_alert_release: assert property (p_alert_release) else $error("alert freed w/o read");
  property p_wd_stall;
    idle_cnt > wd_lim |-> fets_off;
  endproperty
  a_wd_stall: assert property (p_wd_stall) else $error("fets on without tick");
  property p_short_off;
    short_chg_det_i [*6] |-> fets_off;
  endproperty
  a_short_off: assert property (p_short_off) else $error("fets on in short");
  property p_short_alert;
    short_dsg_det_i [*6] |-> !alert_out_n_o;
  endproperty
  a_short_alert: assert property (p_short_alert) else $error("no alert on short");
endmodule // pack_protection_fault_control_sva

bind pack_protection_fault_control pack_protection_fault_control_sva #(
  .WD_START_CYCLES(WD_START_CYCLES)
) i_sva (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .host_tick_in_i(host_tick_in_i),
  .short_dsg_det_i(short_dsg_det_i), .short_chg_det_i(short_chg_det_i),
  .precharge_select_in_i(precharge_select_in_i), .discharge_fet_drive_o(discharge_fet_drive_o),
  .charge_fet_drive_o(charge_fet_drive_o),
  .zero_cell_charge_fet_drive_o(zero_cell_charge_fet_drive_o),
  .alert_out_n_o(alert_out_n_o), .thermistor_bias_out_o(thermistor_bias_out_o),
  .open_drain_out_o(open_drain_out_o), .balance_en_o(balance_en_o));

// File: host_tick_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host tick source, 320 ns period
// ----------------------------------------
module host_tick_model (
  input wire run_i,
  output logic tick_o
);
  // Stands low while stopped, as a halted host oscillator would
  initial begin
    tick_o = 1'b0;
    forever begin
      #160;
      if (run_i) tick_o = ~tick_o;
      else tick_o = 1'b0;
    end
  end
endmodule // host_tick_model

// File: pack_protection_fault_control_tb.sv
`timescale 1ns/1ps
`include "pack_prot_defs.vh"
module pack_protection_fault_control_tb;
  logic clk_i, nrst_i, wr_i, rd_i, run, sleep_pin;
  logic rd_seen = 1'b0;
  logic strap = 1'b1;
  logic ce = 1'b1;
  logic [3:0] addr_i;
  logic [7:0] wdata_i, v;
  logic [2:0] det;
  integer seed = 32'hf26908d9;
  int num_errors = 0;
  int checked = 0;
  logic [7:0] exp_q[$];
  logic [3:0] mcode[5] = '{4'hC, 4'h8, 4'h1, 4'h2, 4'h3};
  logic [2:0] msrc[5] = '{`MON_REF_DIRECT, `MON_REF_SCALED, `MON_CELL_A, `MON_CELL_B, `MON_CELL_C};
  wire [7:0] rdata_o;
  wire discharge_fet_drive, charge_fet_drive, zv, alert_n, thermistor_bias_out, od, tick;
  wire [3:0] bal;
  wire [2:0] mon;
  wire [7:0] fets = {5'h00, discharge_fet_drive, charge_fet_drive, zv};
  wire [7:0] alert_w = {7'h00, alert_n};

  pack_protection_fault_control #(.WD_START_CYCLES(25'd2000), .TICKS_PER_MS(12'd2),
    .TICKS_PER_SC_STEP(12'd1)) i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .host_tick_in_i(tick), .overload_det_i(det[2]), .short_dsg_det_i(det[0]),
    .short_chg_det_i(det[1]), .sleep_pin_i(sleep_pin), .precharge_select_in_i(strap),
    .discharge_fet_drive_o(discharge_fet_drive), .charge_fet_drive_o(charge_fet_drive),
    .zero_cell_charge_fet_drive_o(zv), .alert_out_n_o(alert_n),
    .thermistor_bias_out_o(thermistor_bias_out), .open_drain_out_o(od), .balance_en_o(bal),
    .monitor_src_o(mon));
  host_tick_model i_host (.run_i(run), .tick_o(tick));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  // Arm then release as two writes; a single write would not clear
  task clr(input logic [7:0] req);
    wr(4'h1, 8'h01);
    wr(4'h1, req);
  endtask
  task stop_test;
    $display("Checks %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------
  // Read data monitor
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) chk(8'hEE, 8'h00);
      else chk(rdata_o, exp_q.pop_front());
    end
    rd_seen <= rd_i;
  end

  initial begin
    cyc(100000);
    num_errors++;
    $display("ERROR %0t: run limit reached", $time);
    stop_test;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    nrst_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; addr_i = 4'h0;
    wdata_i = 8'h00; det = 3'h0; sleep_pin = 1'b0; run = 1'b0;
    cyc(8);
    nrst_i <= 1'b1;
    cyc(6);
    chk(fets, 8'h02);
    for (int i = 0; i <= 9; i++) rd((i == 9) ? 4'hF : i[3:0], 8'h00);
    cyc(2100);
    chk(fets, 8'h00);
    rd(4'h0, 8'h08);
    cyc(2);
    chk(alert_w, 8'h00);
    run <= 1'b1;
    cyc(30);
    clr(8'h00);
    rd(4'h0, 8'h00);
    cyc(2);
    chk(alert_w, 8'h01);
    for (int i = 1; i <= 8; i++) begin
      v = $random(seed);
      wr(i[3:0], v);
      rd(i[3:0], v);
    end
    for (int i = 1; i <= 8; i++) wr(i[3:0], 8'h00);
    wr(4'h0, 8'hFF);
    rd(4'h0, 8'h00);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    wr(4'h3, 8'h01);
    for (int i = 0; i < 5; i++) begin
      v = $random(seed);
      wr(4'h4, {v[7:4], mcode[i]});
      cyc(3);
      chk({5'h00, mon}, {5'h00, msrc[i]});
      chk({4'h0, bal}, {4'h0, v[7:4]});
    end
    wr(4'h3, 8'h20);
    wr(4'h1, 8'h10);
    cyc(3);
    chk({3'h0, mon, thermistor_bias_out, od}, 8'h03);
    for (int i = 0; i < 3; i++) begin
      wr(4'h1, 8'h0E);
      cyc(4);
      chk(fets, 8'h07);
      det <= 3'h1 << i;
      cyc(4);
      if (i == 2) chk(fets, 8'h07);
      cyc(40);
      chk(fets, 8'h00);
      chk(alert_w, 8'h00);
      rd(4'h0, 8'h01 << i);
      cyc(2);
      chk(alert_w, 8'h00);
      clr(8'h0E);
      cyc(6);
      chk(fets, 8'h00);
      det <= 3'h0;
      clr(8'h0E);
      cyc(6);
      chk(fets, 8'h07);
      rd(4'h0, 8'h00);
      cyc(2);
      chk(alert_w, 8'h01);
    end
    run <= 1'b0;
    cyc(2600);
    chk(fets, 8'h00);
    chk(alert_w, 8'h00);
    run <= 1'b1;
    cyc(30);
    rd(4'h0, 8'h08);
    wr(4'h1, 8'h0E);
    cyc(4);
    chk(fets, 8'h07);
    clr(8'h0E);
    cyc(4);
    chk(fets, 8'h07);
    sleep_pin <= 1'b1;
    cyc(6);
    chk(alert_w, 8'h00);
    clr(8'h0E);
    rd(4'h0, 8'h10);
    cyc(2);
    chk(alert_w, 8'h01);
    // Second reset with the strap grounded; sleep pin back to idle first
    sleep_pin <= 1'b0;
    strap <= 1'b0;
    nrst_i <= 1'b0;
    cyc(8);
    nrst_i <= 1'b1;
    cyc(6);
    chk(fets, 8'h00);
    // A write while the clock enable is low must not land
    ce <= 1'b0;
    wr(4'h3, 8'h20);
    ce <= 1'b1;
    cyc(3);
    chk({7'h00, thermistor_bias_out}, 8'h00);
    rd(4'h3, 8'h00);
    cyc(2);
    stop_test;
  end
endmodule // pack_protection_fault_control_tb
